/* kdcd_consts.svh */
// Constants of the keypad/display command decoder: field positions,
// reset values, fill codes and timing figures.
// Assumes inclusion by the package only, after its guard.
`ifndef KDCD_CONSTS_SVH
`define KDCD_CONSTS_SVH

// Command word fields
`define KDCD_CMD_MSB        7
`define KDCD_CMD_LSB        5
`define KDCD_AI_BIT         4
`define KDCD_ERR_BIT        4
`define KDCD_INH_A_BIT      3
`define KDCD_INH_B_BIT      2
`define KDCD_HIDE_A_BIT     1
`define KDCD_HIDE_B_BIT     0
`define KDCD_CD_MSB         4
`define KDCD_CD_LSB         2
`define KDCD_CF_BIT         1
`define KDCD_CA_BIT         0

// Command codes
`define KDCD_CODE_MODE      3'h0
`define KDCD_CODE_PRESCALE  3'h1
`define KDCD_CODE_RD_FIFO   3'h2
`define KDCD_CODE_RD_DISP   3'h3
`define KDCD_CODE_WR_DISP   3'h4
`define KDCD_CODE_INH_BLANK 3'h5
`define KDCD_CODE_CLEAR     3'h6
`define KDCD_CODE_END_INT   3'h7

// Reset values, limits and fill codes
`define KDCD_PRESCALE_RST   5'h1F
`define KDCD_PRESCALE_MIN   5'h02
`define KDCD_FILL_ZERO      8'h00
`define KDCD_FILL_HEX20     8'h20
`define KDCD_FILL_ONES      8'hFF
`define KDCD_FIFO_FULL      4'h8
`define KDCD_LAST_ROW       4'hF

// Timing, in microseconds at the nominal reference rate
`define KDCD_REF_HZ         100000
`define KDCD_SCAN_US        5100
`define KDCD_DEBOUNCE_US    10300
`define KDCD_REF_US         (1000000 / `KDCD_REF_HZ)
`define KDCD_SCAN_TICKS     (`KDCD_SCAN_US / `KDCD_REF_US)
`define KDCD_DEBOUNCE_TICKS (`KDCD_DEBOUNCE_US / `KDCD_REF_US)

`endif

/* kdcd_cpu_model.sv */
// Processor model on the decoder's parallel bus.
// Assumes the bench calls wr and rd; pins change at falling edges only.
module kdcd_cpu_model
	import kdcd_pkg::*;
(
	input  wire logic           clk_i,
	input  wire logic [7:0]     data_i,
	output kdcd_pkg::kdcd_bus_s bus_o,
	output logic                rd_vld_o,
	output logic [7:0]          rd_data_o
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		bus_o = {1'b1, 1'b0, 1'b1, 1'b1, 8'hA5};
		rd_vld_o = 1'b0;
		rd_data_o = 8'h00;
	end

	// Released pins flip so a stale value never looks held
	task automatic release_bus();
		bus_o.cs_n = 1'b1;
		bus_o.control_select_line = ~bus_o.control_select_line;
		bus_o.data = ~bus_o.data;
	endtask

	task automatic wr(input logic sel, input logic [7:0] d);
		@(negedge clk_i);
		bus_o.cs_n = 1'b0;
		bus_o.control_select_line = sel;
		bus_o.data = d;
		bus_o.wr_n = 1'b0;
		repeat (4) @(negedge clk_i);
		bus_o.wr_n = 1'b1;
		// Select and data outlive the strobe by the pin sync delay
		repeat (3) @(negedge clk_i);
		release_bus();
		repeat (2) @(negedge clk_i);
	endtask

	task automatic rd(input logic sel);
		@(negedge clk_i);
		bus_o.cs_n = 1'b0;
		bus_o.control_select_line = sel;
		bus_o.rd_n = 1'b0;
		repeat (4) @(negedge clk_i);
		rd_data_o = data_i;
		rd_vld_o = 1'b1;
		bus_o.rd_n = 1'b1;
		release_bus();
		@(negedge clk_i);
		rd_vld_o = 1'b0;
		repeat (4) @(negedge clk_i);
	endtask
endmodule

/* kdcd_decoder.sv */
// Command interpreter, display RAM, FIFO/sensor RAM and status.
// Assumes bus pins are asynchronous; key, sense and display index
// inputs come from scan logic on clk_i.
// Function
// - Reference clock is clock divided by prescale
// - Prescale zero or one divides by two
// - Reset loads 31; clears never touch it
// - Scan 5.1ms, debounce 10.3ms at 100kHz
// - FIFO read command; row and AI sensor-only
// - Sensor AI advances row after each read
// - Display read command loads address, AI
// - Display write shares address; read source kept
// - Inhibit bits protect display nibbles
// - Hide bits blank ports with clear code
// - Data high nibble to A, low to B
// - Clear code fills every display row
// - Clear in progress sets status MSB
// - FIFO clear drops status, IRQ, row pointer
// - Clear-all clears both and resyncs timing
// - End interrupt lowers IRQ in sensor mode only; IRQ blocks sensor
// - Error mode bit drives sensor/error flag
// - Overrun on full push, underrun on empty read
// - Status holds full flag and count
// - Select line high means command or status
// - Data bus released while chip select high
// - FIFO not empty raises IRQ in key modes
module kdcd_decoder (
	input  wire logic                 clk_i,
	input  wire logic                 sys_rst_i,
	input  wire kdcd_pkg::kdcd_bus_s   bus_i,
	output logic [7:0]                data_o,
	output logic                      data_oe_n_o,
	input  wire kdcd_pkg::kdcd_mode_e  input_mode_i,
	input  wire kdcd_pkg::kdcd_key_s   key_i,
	input  wire kdcd_pkg::kdcd_sense_s sense_i,
	input  wire logic [3:0]           disp_index_i,
	output logic [7:0]                mode_word_o,
	output logic [3:0]                out_a_o,
	output logic [3:0]                out_b_o,
	output logic                      blanking_output_n_o,
	output logic                      irq_o,
	output logic                      ref_tick_o,
	output logic                      scan_tick_o,
	output logic                      debounce_tick_o
);
	import kdcd_pkg::*;

	typedef struct packed {
		kdcd_bus_s        bus_s1;
		kdcd_bus_s        bus_s2;
		logic             wr_prev;
		logic             rd_prev;
		logic             wr_act;
		logic             rd_act;
		logic             rd_sel;
		logic [7:0]       wdata;
		logic             wsel;
		logic [4:0]       prescale_value;
		logic [7:0]       mode_word;
		logic             auto_increment_flag;
		logic [3:0]       row_address;
		logic             sens_ai;
		logic [2:0]       sens_row;
		logic             rd_disp;
		logic             inhibit_nibble_a_write;
		logic             inhibit_nibble_b_write;
		logic             hide_nibble_a;
		logic             hide_nibble_b;
		logic [7:0]       blank_code;
		logic             err_mode;
		kdcd_clr_e        clr_st;
		logic [3:0]       clr_row;
		logic [7:0]       clr_code;
		logic             resync;
		logic [7:0][7:0]  fifo;
		logic [15:0][7:0] disp;
		logic [2:0]       wp;
		logic [2:0]       rp;
		logic [3:0]       fifo_char_count;
		logic             ovr;
		logic             und;
		logic             se;
		logic             irq_s;
		logic             irq;
		logic [7:0]       dout;
		logic             oe_n;
		logic [3:0]       out_a;
		logic [3:0]       out_b;
		logic             bd_n;
	} kdcd_state_s;

	kdcd_state_s s_q;
	kdcd_state_s s_d;

	function automatic logic [7:0] fill_code(input logic [2:0] cd);
		logic [7:0] code;
		code = `KDCD_FILL_ZERO;
		if (cd[2] && cd[1]) begin
			code = cd[0] ? `KDCD_FILL_ONES : `KDCD_FILL_HEX20;
		end
		return code;
	endfunction

	////////////////////////////////////////////////////////////////////
	logic       du;
	logic       sensor_md;
	logic       fifo_md;
	logic       spec_err;
	logic       wr_done;
	logic       rd_start;
	logic       rd_done;
	logic [2:0] cd;
	logic [7:0] cur;

	always_comb begin
		s_d = s_q;
		du = (s_q.clr_st == KDCD_CLR_RUN);
		sensor_md = (input_mode_i == KDCD_MODE_SENSOR);
		fifo_md = !sensor_md;
		spec_err = (input_mode_i == KDCD_MODE_KEYN) && s_q.err_mode;
		cd = s_q.wdata[`KDCD_CD_MSB:`KDCD_CD_LSB];
		cur = s_q.disp[s_q.row_address];
		s_d.resync = 1'b0;
		// First stage feeds only the second stage
		s_d.bus_s1 = bus_i;
		s_d.bus_s2 = s_q.bus_s1;
		s_d.wr_prev = s_q.bus_s2.wr_n;
		s_d.rd_prev = s_q.bus_s2.rd_n;
		s_d.oe_n = !(!s_q.bus_s2.cs_n && !s_q.bus_s2.rd_n);
		wr_done = s_q.bus_s2.wr_n && !s_q.wr_prev && s_q.wr_act;
		rd_start = !s_q.bus_s2.rd_n && s_q.rd_prev && !s_q.bus_s2.cs_n;
		rd_done = s_q.bus_s2.rd_n && !s_q.rd_prev && s_q.rd_act;
		// Data is latched through the low phase so hold time is moot
		if (!s_q.bus_s2.wr_n && !s_q.bus_s2.cs_n) begin
			s_d.wdata = s_q.bus_s2.data;
			s_d.wsel = s_q.bus_s2.control_select_line;
			s_d.wr_act = 1'b1;
		end else if (wr_done) begin
			s_d.wr_act = 1'b0;
		end

		// Display clear sequencer, one row per clock
		unique case (s_q.clr_st)
			KDCD_CLR_IDLE: begin
			end
			KDCD_CLR_RUN: begin
				s_d.disp[s_q.clr_row] = s_q.clr_code;
				s_d.clr_row = s_q.clr_row + 4'h1;
				if (s_q.clr_row == `KDCD_LAST_ROW) begin
					s_d.clr_st = KDCD_CLR_IDLE;
				end
			end
		endcase

		////////////////////////////////////////////////////////////////
		if (wr_done && s_q.wsel) begin
			unique case (kdcd_cmd_e'(s_q.wdata[`KDCD_CMD_MSB:`KDCD_CMD_LSB]))
				KDCD_CMD_MODE: begin
					s_d.mode_word = s_q.wdata;
				end
				KDCD_CMD_PRESCALE: begin
					s_d.prescale_value = s_q.wdata[4:0];
				end
				KDCD_CMD_RD_FIFO: begin
					s_d.rd_disp = 1'b0;
					s_d.sens_ai = s_q.wdata[`KDCD_AI_BIT];
					s_d.sens_row = s_q.wdata[2:0];
				end
				KDCD_CMD_RD_DISP: begin
					s_d.rd_disp = 1'b1;
					s_d.auto_increment_flag = s_q.wdata[`KDCD_AI_BIT];
					s_d.row_address = s_q.wdata[3:0];
				end
				KDCD_CMD_WR_DISP: begin
					s_d.auto_increment_flag = s_q.wdata[`KDCD_AI_BIT];
					s_d.row_address = s_q.wdata[3:0];
				end
				KDCD_CMD_INH_BLANK: begin
					s_d.inhibit_nibble_a_write = s_q.wdata[`KDCD_INH_A_BIT];
					s_d.inhibit_nibble_b_write = s_q.wdata[`KDCD_INH_B_BIT];
					s_d.hide_nibble_a = s_q.wdata[`KDCD_HIDE_A_BIT];
					s_d.hide_nibble_b = s_q.wdata[`KDCD_HIDE_B_BIT];
				end
				KDCD_CMD_CLEAR: begin
					if (cd[2] || s_q.wdata[`KDCD_CA_BIT]) begin
						s_d.clr_st = KDCD_CLR_RUN;
						s_d.clr_row = 4'h0;
						s_d.clr_code = fill_code(cd);
						s_d.blank_code = fill_code(cd);
					end
					if (s_q.wdata[`KDCD_CF_BIT] || s_q.wdata[`KDCD_CA_BIT]) begin
						s_d.fifo_char_count = 4'h0;
						s_d.wp = 3'h0;
						s_d.rp = 3'h0;
						s_d.ovr = 1'b0;
						s_d.und = 1'b0;
						s_d.se = 1'b0;
						s_d.irq_s = 1'b0;
						s_d.sens_row = 3'h0;
					end
					s_d.resync = s_q.wdata[`KDCD_CA_BIT];
				end
				KDCD_CMD_END_INT: begin
					s_d.err_mode = s_q.wdata[`KDCD_ERR_BIT];
					if (sensor_md) begin
						s_d.irq_s = 1'b0;
						if (!s_q.wdata[`KDCD_ERR_BIT]) begin
							s_d.se = 1'b0;
						end
					end
				end
			endcase
		end else if (wr_done && !du) begin
			// Writes during a clear are dropped; the processor waits
			s_d.disp[s_q.row_address] = {
				s_q.inhibit_nibble_a_write ? cur[7:4] : s_q.wdata[7:4],
				s_q.inhibit_nibble_b_write ? cur[3:0] : s_q.wdata[3:0]
			};
			if (s_q.auto_increment_flag) begin
				s_d.row_address = s_q.row_address + 4'h1;
			end
		end

		////////////////////////////////////////////////////////////////
		if (rd_start) begin
			s_d.rd_act = 1'b1;
			s_d.rd_sel = s_q.bus_s2.control_select_line;
			if (s_q.bus_s2.control_select_line) begin
				s_d.dout = {du, s_q.se, s_q.ovr, s_q.und,
					s_q.fifo_char_count == `KDCD_FIFO_FULL,
					s_q.fifo_char_count[2:0]};
			end else if (s_q.rd_disp) begin
				s_d.dout = s_q.disp[s_q.row_address];
			end else if (sensor_md) begin
				s_d.dout = s_q.fifo[s_q.sens_row];
			end else begin
				s_d.dout = s_q.fifo[s_q.rp];
			end
		end else if (rd_done) begin
			s_d.rd_act = 1'b0;
			if (s_q.rd_sel) begin
			end else if (s_q.rd_disp) begin
				if (s_q.auto_increment_flag) begin
					s_d.row_address = s_q.row_address + 4'h1;
				end
			end else if (sensor_md) begin
				if (s_q.sens_ai) begin
					s_d.sens_row = s_q.sens_row + 3'h1;
				end else begin
					s_d.irq_s = 1'b0;
				end
			end else if (s_q.fifo_char_count == 4'h0) begin
				s_d.und = 1'b1;
			end else begin
				s_d.rp = s_q.rp + 3'h1;
				s_d.fifo_char_count = s_d.fifo_char_count - 4'h1;
			end
		end

		////////////////////////////////////////////////////////////////
		// Entries come last so a same-cycle clear never eats an event
		if (fifo_md && key_i.valid) begin
			if (spec_err && key_i.multi_err) begin
				s_d.se = 1'b1;
			end else if (spec_err && s_q.se) begin
			end else if (s_d.fifo_char_count == `KDCD_FIFO_FULL) begin
				s_d.ovr = 1'b1;
			end else begin
				s_d.fifo[s_d.wp] = key_i.data;
				s_d.wp = s_d.wp + 3'h1;
				s_d.fifo_char_count = s_d.fifo_char_count + 4'h1;
			end
		end
		if (sensor_md && sense_i.valid && !s_q.irq_s) begin
			if (sense_i.data != s_q.fifo[sense_i.row]) begin
				s_d.irq_s = 1'b1;
			end
			s_d.fifo[sense_i.row] = sense_i.data;
			if (s_d.err_mode && (sense_i.data != 8'h00)) begin
				s_d.se = 1'b1;
			end
		end

		if (sensor_md) begin
			s_d.irq = s_d.irq_s;
		end else begin
			s_d.irq = (s_d.fifo_char_count != 4'h0) || (spec_err && s_d.se);
		end

		s_d.out_a = s_q.hide_nibble_a ? s_q.blank_code[7:4] :
			s_q.disp[disp_index_i][7:4];
		s_d.out_b = s_q.hide_nibble_b ? s_q.blank_code[3:0] :
			s_q.disp[disp_index_i][3:0];
		s_d.bd_n = !(s_q.hide_nibble_a && s_q.hide_nibble_b);
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			s_q <= '0;
			s_q.bus_s1 <= '1;
			s_q.bus_s2 <= '1;
			s_q.wr_prev <= 1'b1;
			s_q.rd_prev <= 1'b1;
			s_q.prescale_value <= `KDCD_PRESCALE_RST;
			s_q.clr_st <= KDCD_CLR_IDLE;
			s_q.oe_n <= 1'b1;
			s_q.bd_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Divider lives apart so scan logic can reuse its ticks
	kdcd_timebase u_timebase (
		.clk_i            (clk_i),
		.sys_rst_i        (sys_rst_i),
		.prescale_value_i (s_q.prescale_value),
		.resync_i         (s_q.resync),
		.ref_tick_o       (ref_tick_o),
		.scan_tick_o      (scan_tick_o),
		.debounce_tick_o  (debounce_tick_o)
	);

	assign data_o = s_q.dout;
	assign data_oe_n_o = s_q.oe_n;
	assign mode_word_o = s_q.mode_word;
	assign out_a_o = s_q.out_a;
	assign out_b_o = s_q.out_b;
	assign blanking_output_n_o = s_q.bd_n;
	assign irq_o = s_q.irq;
endmodule

/* kdcd_decoder_sva.sv */
// Port checker for the keypad/display command decoder.
// Assumes one clock, clk_i, and synchronous reset sys_rst_i.
module kdcd_decoder_sva
	import kdcd_pkg::*;
(
	input wire logic                 clk_i,
	input wire logic                 sys_rst_i,
	input wire kdcd_pkg::kdcd_bus_s  bus_i,
	input wire logic                 data_oe_n_o,
	input wire kdcd_pkg::kdcd_mode_e input_mode_i,
	input wire kdcd_pkg::kdcd_key_s  key_i,
	input wire logic [3:0]           out_a_o,
	input wire logic [3:0]           out_b_o,
	input wire logic                 blanking_output_n_o,
	input wire logic                 irq_o,
	input wire logic                 ref_tick_o
);
	logic [5:0] gap_q;

	// Saturates so a stuck divider cannot wrap back into range
	always_ff @(posedge clk_i)
		if (sys_rst_i || ref_tick_o)
			gap_q <= 6'h00;
		else if (gap_q != 6'h3F)
			gap_q <= gap_q + 6'h01;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	a_reset_quiet: assert property (
		$fell(sys_rst_i) |-> data_oe_n_o && !irq_o && blanking_output_n_o)
		else $error("outputs not idle after reset");
	a_cs_release: assert property (
		bus_i.cs_n [*5] |-> data_oe_n_o)
		else $error("data bus driven while deselected");
	a_rd_drive: assert property (
		(!bus_i.cs_n && !bus_i.rd_n) [*4] |-> !data_oe_n_o)
		else $error("read not driven");
	a_rd_idle: assert property (
		bus_i.rd_n [*5] |-> data_oe_n_o)
		else $error("data bus held after read");
	a_ref_single: assert property (
		ref_tick_o |=> !ref_tick_o)
		else $error("reference divisor below two");
	a_ref_gap: assert property (
		gap_q <= 6'h1F)
		else $error("reference gap above 31");
	a_irq_key: assert property (
		key_i.valid && input_mode_i == KDCD_MODE_KEY2 |=> irq_o)
		else $error("no irq after key entry");
	a_irq_cause: assert property (
		$rose(irq_o) && input_mode_i == KDCD_MODE_KEY2 |-> $past(key_i.valid))
		else $error("irq rose without key entry");
	a_blank_code: assert property (
		!blanking_output_n_o |-> {out_a_o, out_b_o} inside {8'h00, 8'h20, 8'hFF})
		else $error("blanked ports not at blank code");

	c_irq: cover property ($rose(irq_o));
	c_blank: cover property (!blanking_output_n_o);
	c_div2: cover property (ref_tick_o ##2 ref_tick_o);
endmodule

bind kdcd_decoder kdcd_decoder_sva i_sva (
	.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_i(bus_i),
	.data_oe_n_o(data_oe_n_o), .input_mode_i(input_mode_i), .key_i(key_i),
	.out_a_o(out_a_o), .out_b_o(out_b_o),
	.blanking_output_n_o(blanking_output_n_o), .irq_o(irq_o),
	.ref_tick_o(ref_tick_o));

/* kdcd_pkg.sv */
// Types of the keypad/display command decoder.
// Assumes kdcd_consts.svh is on the include path.
package kdcd_pkg;
`include "kdcd_consts.svh"

	typedef enum logic [2:0] {
		KDCD_CMD_MODE      = `KDCD_CODE_MODE,
		KDCD_CMD_PRESCALE  = `KDCD_CODE_PRESCALE,
		KDCD_CMD_RD_FIFO   = `KDCD_CODE_RD_FIFO,
		KDCD_CMD_RD_DISP   = `KDCD_CODE_RD_DISP,
		KDCD_CMD_WR_DISP   = `KDCD_CODE_WR_DISP,
		KDCD_CMD_INH_BLANK = `KDCD_CODE_INH_BLANK,
		KDCD_CMD_CLEAR     = `KDCD_CODE_CLEAR,
		KDCD_CMD_END_INT   = `KDCD_CODE_END_INT
	} kdcd_cmd_e;

	typedef enum logic [1:0] {
		KDCD_MODE_KEY2   = 2'h0,
		KDCD_MODE_KEYN   = 2'h1,
		KDCD_MODE_SENSOR = 2'h2,
		KDCD_MODE_STROBE = 2'h3
	} kdcd_mode_e;

	typedef enum logic [1:0] {
		KDCD_CLR_IDLE = 2'h1,
		KDCD_CLR_RUN  = 2'h2
	} kdcd_clr_e;

	// Processor pins, strobes and chip select active low, select line and data not
	typedef struct packed {
		logic       cs_n;
		logic       control_select_line;
		logic       rd_n;
		logic       wr_n;
		logic [7:0] data;
	} kdcd_bus_s;

	// Character from the key or strobe front end
	typedef struct packed {
		logic       valid;
		logic       multi_err;
		logic [7:0] data;
	} kdcd_key_s;

	// Row of return-line state from the sensor scan
	typedef struct packed {
		logic       valid;
		logic [2:0] row;
		logic [7:0] data;
	} kdcd_sense_s;

	typedef struct packed {
		logic [4:0]  div_cnt;
		logic [9:0]  scan_cnt;
		logic [10:0] deb_cnt;
		logic        ref_tick;
		logic        scan_tick;
		logic        deb_tick;
	} kdcd_time_s;
endpackage

/* kdcd_timebase.sv */
// Prescaler and scan/debounce counter chain.
// Assumes prescale_value_i is held stable by the command logic on clk_i.
module kdcd_timebase (
	input  wire logic       clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic [4:0] prescale_value_i,
	input  wire logic       resync_i,
	output logic            ref_tick_o,
	output logic            scan_tick_o,
	output logic            debounce_tick_o
);
	import kdcd_pkg::*;

	localparam logic [9:0]  SCAN_LAST = 10'(`KDCD_SCAN_TICKS - 1);
	localparam logic [10:0] DEB_LAST  = 11'(`KDCD_DEBOUNCE_TICKS - 1);

	kdcd_time_s s_q;
	kdcd_time_s s_d;
	logic [4:0] divisor;

	////////////////////////////////////////////////////////////////////
	always_comb begin
		s_d = s_q;
		divisor = (prescale_value_i < `KDCD_PRESCALE_MIN) ?
			`KDCD_PRESCALE_MIN : prescale_value_i;
		s_d.ref_tick = 1'b0;
		s_d.scan_tick = 1'b0;
		s_d.deb_tick = 1'b0;
		if (s_q.div_cnt >= divisor - 5'h01) begin
			s_d.div_cnt = 5'h00;
			s_d.ref_tick = 1'b1;
		end else begin
			s_d.div_cnt = s_q.div_cnt + 5'h01;
		end
		if (s_q.ref_tick) begin
			if (s_q.scan_cnt == SCAN_LAST) begin
				s_d.scan_cnt = 10'h000;
				s_d.scan_tick = 1'b1;
			end else begin
				s_d.scan_cnt = s_q.scan_cnt + 10'h001;
			end
			if (s_q.deb_cnt == DEB_LAST) begin
				s_d.deb_cnt = 11'h000;
				s_d.deb_tick = 1'b1;
			end else begin
				s_d.deb_cnt = s_q.deb_cnt + 11'h001;
			end
		end
		// Resync restarts the whole chain from a clean phase
		if (resync_i) begin
			s_d = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign ref_tick_o = s_q.ref_tick;
	assign scan_tick_o = s_q.scan_tick;
	assign debounce_tick_o = s_q.deb_tick;
endmodule

/* tb_top.sv */
// Self-checking bench for the keypad/display command decoder.
// Assumes kdcd_cpu_model drives the bus and the checker is bound.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import kdcd_pkg::*;

	logic        clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	kdcd_bus_s   bus;
	logic [7:0]  dout;
	logic        oe_n;
	kdcd_mode_e  mode = KDCD_MODE_KEY2;
	kdcd_key_s   key = '0;
	kdcd_sense_s sense = '0;
	logic [3:0]  idx = 4'h0;
	logic [7:0]  mword;
	logic [3:0]  out_a;
	logic [3:0]  out_b;
	logic        blank_n;
	logic        irq;
	logic        ref_tick;
	logic        scan_tick;
	logic        deb_tick;
	logic        rd_vld;
	logic [7:0]  rd_data;
	logic [7:0]  v;
	logic [7:0]  exp_q [$];
	logic [7:0]  mem [16];
	logic [4:0]  pre [4] = '{5'h00, 5'h01, 5'h02, 5'h07};
	logic [7:0]  clr [3] = '{8'hD0, 8'hD8, 8'hDC};
	logic [7:0]  fill [3] = '{8'h00, 8'h20, 8'hFF};
	integer      seed = 32'h1FFE;
	int          bad_count = 0;
	int          n_compared = 0;
	int          cycles = 0;

	kdcd_decoder i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_i(bus),
		.data_o(dout), .data_oe_n_o(oe_n), .input_mode_i(mode),
		.key_i(key), .sense_i(sense), .disp_index_i(idx),
		.mode_word_o(mword), .out_a_o(out_a), .out_b_o(out_b),
		.blanking_output_n_o(blank_n), .irq_o(irq),
		.ref_tick_o(ref_tick), .scan_tick_o(scan_tick),
		.debounce_tick_o(deb_tick));
	kdcd_cpu_model i_cpu (.clk_i(clk_i), .data_i(dout), .bus_o(bus),
		.rd_vld_o(rd_vld), .rd_data_o(rd_data));

	initial forever #12.5 clk_i = ~clk_i;

	////////////////////////////////////////
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		n_compared++;
		if (seen !== want) begin
			bad_count++;
			$display("ERROR %0t seen %h want %h", $time, seen, want);
		end
	endtask

	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic rdx(input logic sel, input logic [7:0] want);
		exp_q.push_back(want);
		i_cpu.rd(sel);
	endtask

	// First tick may belong to the old divisor, so measure the next gap
	task automatic tick_gap(input int want);
		int n;
		n = 0;
		do @(posedge clk_i); while (ref_tick !== 1'b1);
		do begin
			@(posedge clk_i);
			n++;
		end while (ref_tick !== 1'b1);
		check(8'(n), 8'(want));
	endtask

	// Reference ticks between two scan or two debounce ticks
	task automatic chain_gap(input logic deb, input int want);
		int n;
		n = 0;
		do @(posedge clk_i); while ((deb ? deb_tick : scan_tick) !== 1'b1);
		do begin
			@(posedge clk_i);
			n += int'(ref_tick);
		end while ((deb ? deb_tick : scan_tick) !== 1'b1);
		check(8'(n), 8'(want));
		check(8'(n >> 8), 8'(want >> 8));
	endtask

	task automatic push_key(input logic [7:0] d, input logic me = 1'b0);
		@(negedge clk_i) key = '{1'b1, me, d};
		@(negedge clk_i) key.valid = 1'b0;
	endtask

	task automatic push_row(input logic [7:0] d);
		@(negedge clk_i) sense = '{1'b1, 3'h3, d};
		@(negedge clk_i) sense.valid = 1'b0;
		repeat (2) @(negedge clk_i);
		check({7'h00, irq}, 8'h01);
	endtask

	always @(posedge clk_i)
		if (rd_vld === 1'b1 && exp_q.size() > 0)
			check(rd_data, exp_q.pop_front());

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 60000) begin
			bad_count++;
			$display("ERROR %0t run too long", $time);
			summarize();
		end
	end

	////////////////////////////////////////
	initial begin
		repeat (16) @(negedge clk_i);
		sys_rst_i = 1'b0;
		rdx(1'b1, 8'h00);
		tick_gap(31);
		i_cpu.wr(1'b1, 8'h08);
		check(mword, 8'h08);
		foreach (pre[i]) begin
			i_cpu.wr(1'b1, {3'h1, pre[i]});
			tick_gap(pre[i] < 5'h02 ? 2 : int'(pre[i]));
			// Shortest divisor keeps the long chain measurement cheap
			if (i == 0) begin
				chain_gap(1'b0, 510);
				chain_gap(1'b1, 1030);
			end
		end
		i_cpu.wr(1'b1, 8'hC1);
		repeat (20) @(negedge clk_i);
		tick_gap(7);
		i_cpu.wr(1'b1, 8'h90);
		for (int i = 0; i < 16; i++) begin
			mem[i] = 8'($random(seed));
			i_cpu.wr(1'b0, mem[i]);
		end
		for (int k = 0; k < 2; k++) begin
			i_cpu.wr(1'b1, k ? 8'hA4 : 8'hA8);
			i_cpu.wr(1'b1, 8'h85 + 8'(k));
			v = 8'($random(seed));
			i_cpu.wr(1'b0, v);
			mem[5+k] = k ? {v[7:4], mem[6][3:0]} : {mem[5][7:4], v[3:0]};
		end
		i_cpu.wr(1'b1, 8'hA0);
		i_cpu.wr(1'b1, 8'h70);
		for (int i = 0; i < 17; i++)
			rdx(1'b0, mem[i%16]);
		for (int i = 0; i < 3; i++) begin
			@(negedge clk_i) idx = 4'($random(seed));
			repeat (4) @(negedge clk_i);
			check({out_a, out_b}, mem[idx]);
		end
		for (int k = 0; k < 3; k++) begin
			i_cpu.wr(1'b1, clr[k]);
			repeat (20) @(negedge clk_i);
			i_cpu.wr(1'b1, 8'hA3);
			check({out_a, out_b}, fill[k]);
			check({7'h00, blank_n}, 8'h00);
			i_cpu.wr(1'b1, 8'hA0);
			check({out_a, out_b}, fill[k]);
		end
		// Nine entries: the last one overruns a full queue
		for (int i = 0; i < 9; i++) begin
			v = 8'($random(seed));
			if (i < 8)
				mem[i] = v;
			push_key(v);
		end
		check({7'h00, irq}, 8'h01);
		rdx(1'b1, 8'h28);
		i_cpu.wr(1'b1, 8'h40);
		for (int i = 0; i < 8; i++)
			rdx(1'b0, mem[i]);
		check({7'h00, irq}, 8'h00);
		i_cpu.rd(1'b0);
		rdx(1'b1, 8'h30);
		i_cpu.wr(1'b1, 8'hC2);
		rdx(1'b1, 8'h00);
		check({out_a, out_b}, 8'hFF);
		mode = KDCD_MODE_SENSOR;
		// Differs from the row's old content so a change is seen
		v = mem[3] ^ (8'($random(seed)) | 8'h01);
		push_row(v);
		push_row(~v);
		i_cpu.wr(1'b1, 8'h43);
		rdx(1'b0, v);
		for (int k = 0; k < 2; k++) begin
			v = ~v;
			push_row(v);
			i_cpu.wr(1'b1, k ? 8'hC2 : 8'hE0);
			check({7'h00, irq}, 8'h00);
		end
		i_cpu.wr(1'b1, 8'h53);
		rdx(1'b0, v);
		rdx(1'b0, mem[4]);
		i_cpu.wr(1'b1, 8'hF0);
		v = {~v[7:1], 1'b1};
		push_row(v);
		rdx(1'b1, 8'h40);
		i_cpu.wr(1'b1, 8'hC2);
		mode = KDCD_MODE_KEYN;
		push_key(v, 1'b1);
		push_key(~v);
		check({7'h00, irq}, 8'h01);
		rdx(1'b1, 8'h40);
		summarize();
	end
endmodule
